// ### gxp_consts.svh
`ifndef GXP_CONSTS_SVH
`define GXP_CONSTS_SVH

// ==========================================================
// slave address: upper six bits fixed, lowest bit from the select pin
`define GXP_ADDR_HI     6'h10

// ==========================================================
// register pointer layout: bit 0 picks the group, bits 2:1 the kind
`define GXP_PTR_GRP     0
`define GXP_PTR_KIND_HI 2
`define GXP_PTR_KIND_LO 1
`define GXP_PTR_RST     3'h0

// ==========================================================
// reset values of the per-group registers
`define GXP_CFG_RST     8'hff
`define GXP_OUT_RST     8'hff
`define GXP_POL_RST     8'h00
`define GXP_HELD_RST    8'h00

// ==========================================================
// serial framing
`define GXP_BYTE_BITS   4'h8
`define GXP_CNT_RST     4'h0

`endif

// ### gxp_pkg.sv
// ==========================================================
// shared types of the expander
package gxp_pkg;

  // register kind, taken from pointer bits 2:1
  typedef enum logic [1:0] {
    GXP_KIND_IN  = 2'h0,
    GXP_KIND_OUT = 2'h1,
    GXP_KIND_POL = 2'h2,
    GXP_KIND_CFG = 2'h3
  } gxp_kind_t;

  // serial engine states, one-hot
  typedef enum logic [8:0] {
    GXP_IDLE      = 9'h001,
    GXP_ADDR      = 9'h002,
    GXP_ADDR_ACK  = 9'h004,
    GXP_CMD       = 9'h008,
    GXP_CMD_ACK   = 9'h010,
    GXP_WDATA     = 9'h020,
    GXP_WDATA_ACK = 9'h040,
    GXP_RDATA     = 9'h080,
    GXP_RDATA_ACK = 9'h100
  } gxp_state_t;

endpackage : gxp_pkg

// ### gxp_bank_if.sv
`timescale 1ns/1ps
// ==========================================================
// register access between the core and one group of eight lines
interface gxp_bank_if;
  logic              wr;        // one-cycle write strobe
  logic              rd_cap;    // one-cycle input capture strobe
  gxp_pkg::gxp_kind_t kind;     // register kind addressed
  logic [7:0]        wdata;     // write data
  logic [7:0]        in_val;    // live input after inversion
  logic [7:0]        out_val;   // output register
  logic [7:0]        pol_val;   // inversion register
  logic [7:0]        cfg_val;   // direction register
  logic [7:0]        mismatch;  // input lines differing from held value

  modport ctrl (output wr, rd_cap, kind, wdata,
                input  in_val, out_val, pol_val, cfg_val, mismatch);
  modport bank (input  wr, rd_cap, kind, wdata,
                output in_val, out_val, pol_val, cfg_val, mismatch);
endinterface : gxp_bank_if

// ### gxp_sync2.sv
`timescale 1ns/1ps
// ==========================================================
// two-flop synchroniser; only q may be read by other logic
module gxp_sync2 #(
  parameter int W = 1
) (
  input  wire logic [W-1:0] d,
  input  wire logic         clk,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;  // first stage, read by the second only

  // no reset: the chain flushes itself within two edges
  always_ff @(posedge clk) begin
    meta <= d;
    q    <= meta;
  end
endmodule : gxp_sync2

// ### gxp_port_bank.sv
`timescale 1ns/1ps
`include "gxp_consts.svh"
// ==========================================================
// one group of eight port lines and its four registers
module gxp_port_bank (
  input  wire logic       clk,
  input  wire logic       rst,
  gxp_bank_if.bank        bus,
  input  wire logic [7:0] pin_i,
  output logic      [7:0] pin_o,
  output logic      [7:0] pin_oe
);
  logic [7:0] live;    // synchronised pin levels
  logic [7:0] cfg;     // direction, one means input
  logic [7:0] pol;     // inversion per line
  logic [7:0] held;    // captured input value
  logic       primed;  // held loaded once after reset

  // ==========================================================
  // pin sampling
  gxp_sync2 #(.W(8)) u_pin_sync (
    .d   (pin_i),
    .clk (clk),
    .q   (live)
  );

  // direction register; all lines inputs after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg <= `GXP_CFG_RST;
    end else if (bus.wr && bus.kind == gxp_pkg::GXP_KIND_CFG) begin
      cfg <= bus.wdata;
    end
  end

  // output latch drives pin_o straight
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_o <= `GXP_OUT_RST;
    end else if (bus.wr && bus.kind == gxp_pkg::GXP_KIND_OUT) begin
      pin_o <= bus.wdata;
    end
  end

  // inversion register
  always_ff @(posedge clk) begin
    if (rst) begin
      pol <= `GXP_POL_RST;
    end else if (bus.wr && bus.kind == gxp_pkg::GXP_KIND_POL) begin
      pol <= bus.wdata;
    end
  end

  // driver enable follows direction one cycle later
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_oe <= 8'h00;
    end else begin
      pin_oe <= ~cfg;
    end
  end

  // held value: first load after reset, then on every input read
  always_ff @(posedge clk) begin
    if (rst) begin
      held   <= `GXP_HELD_RST;
      primed <= 1'b0;
    end else if (!primed || bus.rd_cap) begin
      held   <= live;
      primed <= 1'b1;
    end
  end

  assign bus.in_val   = live ^ pol;
  assign bus.out_val  = pin_o;
  assign bus.pol_val  = pol;
  assign bus.cfg_val  = cfg;
  // only lines set as inputs may flag a change
  assign bus.mismatch = primed ? ((live ^ held) & cfg) : 8'h00;
endmodule : gxp_port_bank

// ### gxp_i2c_gpio16.sv
`timescale 1ns/1ps
`include "gxp_consts.svh"
// ==========================================================
// sixteen-line expander behind a two-wire serial slave
// port bit 0 is port_line_low_group_bit0,
// port bit 15 is port_line_high_group_bit7
module gxp_i2c_gpio16 (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        link_clk,
  input  wire logic        reset_n,
  input  wire logic        addr_sel,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             int_n_o,
  output logic             int_n_oe,
  input  wire logic [15:0] port_i,
  output logic      [15:0] port_o,
  output logic      [15:0] port_oe
);

  // ==========================================================
  // core clock domain: reset
  logic       pin_rst;    // reset pin, synchronised
  logic       rst;        // combined core reset

  // core side of the request crossing
  logic       req_s;      // synchronised request toggle
  logic       req_d;      // previous request toggle
  logic       req_new;    // one-cycle request pulse
  logic       ack_tgl;    // answer toggle back to link
  logic [7:0] rd_data;    // read answer, stable until next
  logic [7:0] next_rd;    // read mux output
  gxp_pkg::gxp_kind_t req_kind;  // kind of requested register

  // link domain
  logic       lrst;       // reset seen in link domain
  logic [2:0] pins_s;     // addr_sel, scl, sda synchronised
  logic       addr_s;     // address pin level
  logic       scl_s;      // clock line level
  logic       sda_s;      // data line level
  logic       scl_d;      // clock line one cycle back
  logic       sda_d;      // data line one cycle back
  logic       ack_s;      // synchronised answer toggle
  logic       ack_d;      // previous answer toggle
  logic [7:0] rd_byte;    // read byte taken over by link
  gxp_pkg::gxp_state_t st;  // serial engine state
  logic [3:0] cnt;        // bits seen in current byte
  logic [7:0] shift;      // receive shifter
  logic [7:0] tx;         // transmit shifter
  logic       rw;         // direction bit of address byte
  logic       nack;       // master refused last read byte
  logic [2:0] ptr;        // register pointer
  logic       req_tgl;    // request toggle to core
  logic       req_we;     // request is a write
  logic [2:0] req_ptr;    // register of request
  logic [7:0] req_data;   // write data of request

  // bank carriers
  gxp_bank_if bif0 ();
  gxp_bank_if bif1 ();

  // ==========================================================
  // reset: power-on reset or the pin, same effect
  gxp_sync2 #(.W(1)) u_rst_sync (
    .d   (~reset_n),
    .clk (clk),
    .q   (pin_rst)
  );
  assign rst = srst | pin_rst;

  // reset level carried into the link domain
  gxp_sync2 #(.W(1)) u_lrst_sync (
    .d   (rst),
    .clk (link_clk),
    .q   (lrst)
  );

  // ==========================================================
  // the two groups of eight lines
  gxp_port_bank u_bank0 (
    .clk    (clk),
    .rst    (rst),
    .bus    (bif0.bank),
    .pin_i  (port_i[7:0]),
    .pin_o  (port_o[7:0]),
    .pin_oe (port_oe[7:0])
  );

  gxp_port_bank u_bank1 (
    .clk    (clk),
    .rst    (rst),
    .bus    (bif1.bank),
    .pin_i  (port_i[15:8]),
    .pin_o  (port_o[15:8]),
    .pin_oe (port_oe[15:8])
  );

  // ==========================================================
  // core side of the request handshake
  gxp_sync2 #(.W(1)) u_req_sync (
    .d   (req_tgl),
    .clk (clk),
    .q   (req_s)
  );

  // edge of the toggle marks a new request
  always_ff @(posedge clk) begin
    if (rst) begin
      req_d <= 1'b0;
    end else begin
      req_d <= req_s;
    end
  end
  assign req_new  = req_s ^ req_d;
  // request words are held still by the link until answered
  assign req_kind = gxp_pkg::gxp_kind_t'(req_ptr[`GXP_PTR_KIND_HI:`GXP_PTR_KIND_LO]);

  // strobes into the addressed group
  assign bif0.wr     = req_new & req_we & ~req_ptr[`GXP_PTR_GRP];
  assign bif1.wr     = req_new & req_we & req_ptr[`GXP_PTR_GRP];
  assign bif0.rd_cap = req_new & ~req_we & ~req_ptr[`GXP_PTR_GRP]
                       & (req_kind == gxp_pkg::GXP_KIND_IN);
  assign bif1.rd_cap = req_new & ~req_we & req_ptr[`GXP_PTR_GRP]
                       & (req_kind == gxp_pkg::GXP_KIND_IN);
  assign bif0.kind   = req_kind;
  assign bif1.kind   = req_kind;
  assign bif0.wdata  = req_data;
  assign bif1.wdata  = req_data;

  // read mux over all eight registers
  always_comb begin
    next_rd = 8'h00;
    unique case (req_kind)
      gxp_pkg::GXP_KIND_IN: begin
        next_rd = req_ptr[`GXP_PTR_GRP] ? bif1.in_val : bif0.in_val;
      end
      gxp_pkg::GXP_KIND_OUT: begin
        next_rd = req_ptr[`GXP_PTR_GRP] ? bif1.out_val : bif0.out_val;
      end
      gxp_pkg::GXP_KIND_POL: begin
        next_rd = req_ptr[`GXP_PTR_GRP] ? bif1.pol_val : bif0.pol_val;
      end
      gxp_pkg::GXP_KIND_CFG: begin
        next_rd = req_ptr[`GXP_PTR_GRP] ? bif1.cfg_val : bif0.cfg_val;
      end
    endcase
  end

  // answer word and toggle; writes are answered too
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= 8'h00;
      ack_tgl <= 1'b0;
    end else if (req_new) begin
      if (!req_we) begin
        rd_data <= next_rd;
      end
      ack_tgl <= ~ack_tgl;
    end
  end

  // ==========================================================
  // interrupt: open drain, low while any input line changed
  always_ff @(posedge clk) begin
    if (rst) begin
      int_n_oe <= 1'b0;
    end else begin
      int_n_oe <= |{bif1.mismatch, bif0.mismatch};
    end
  end

  // the pad only ever pulls low; the pull-up gives the high
  always_ff @(posedge clk) begin
    int_n_o <= 1'b0;
  end

  // ==========================================================
  // link domain: line sampling
  gxp_sync2 #(.W(3)) u_pin_sync (
    .d   ({addr_sel, scl_i, sda_i}),
    .clk (link_clk),
    .q   (pins_s)
  );
  assign addr_s = pins_s[2];
  assign scl_s  = pins_s[1];
  assign sda_s  = pins_s[0];

  // previous levels for edge and condition detection
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // answer crossing: word is stable once the toggle arrives
  gxp_sync2 #(.W(1)) u_ack_sync (
    .d   (ack_tgl),
    .clk (link_clk),
    .q   (ack_s)
  );

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      ack_d   <= 1'b0;
      rd_byte <= 8'h00;
    end else begin
      ack_d <= ack_s;
      if (ack_s ^ ack_d) begin
        rd_byte <= rd_data;
      end
    end
  end

  // ==========================================================
  // serial engine
  logic rise;      // clock line rising
  logic fall;      // clock line falling
  logic start_ev;  // data falls while clock high
  logic stop_ev;   // data rises while clock high
  logic byte_end;  // eight bits counted
  logic addr_hit;  // address byte is ours
  assign rise     = scl_s & ~scl_d;
  assign fall     = ~scl_s & scl_d;
  assign start_ev = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_ev  = scl_s & scl_d & ~sda_d & sda_s;
  assign byte_end = (cnt == `GXP_BYTE_BITS);
  assign addr_hit = (shift[7:1] == {`GXP_ADDR_HI, addr_s});

  // state, bit count and receive shifter
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      st    <= gxp_pkg::GXP_IDLE;
      cnt   <= `GXP_CNT_RST;
      shift <= 8'h00;
      rw    <= 1'b0;
      nack  <= 1'b0;
    end else if (start_ev) begin
      st  <= gxp_pkg::GXP_ADDR;  // also a repeated start
      cnt <= `GXP_CNT_RST;
    end else if (stop_ev) begin
      st <= gxp_pkg::GXP_IDLE;
    end else if (rise) begin
      // receive bits are taken while the clock is high
      if (st inside {gxp_pkg::GXP_ADDR, gxp_pkg::GXP_CMD, gxp_pkg::GXP_WDATA}) begin
        shift <= {shift[6:0], sda_s};
        cnt   <= cnt + 4'h1;
      end
      if (st == gxp_pkg::GXP_RDATA) begin
        cnt <= cnt + 4'h1;
      end
      if (st == gxp_pkg::GXP_RDATA_ACK) begin
        nack <= sda_s;
      end
    end else if (fall) begin
      unique case (st)
        gxp_pkg::GXP_IDLE: begin
          cnt <= `GXP_CNT_RST;
        end
        gxp_pkg::GXP_ADDR: begin
          if (byte_end) begin
            // a foreign address leaves the bus alone until the next start
            st <= addr_hit ? gxp_pkg::GXP_ADDR_ACK : gxp_pkg::GXP_IDLE;
            rw <= shift[0];
          end
        end
        gxp_pkg::GXP_CMD: begin
          if (byte_end) begin
            st <= gxp_pkg::GXP_CMD_ACK;
          end
        end
        gxp_pkg::GXP_WDATA: begin
          if (byte_end) begin
            st <= gxp_pkg::GXP_WDATA_ACK;
          end
        end
        gxp_pkg::GXP_ADDR_ACK: begin
          st  <= rw ? gxp_pkg::GXP_RDATA : gxp_pkg::GXP_CMD;
          cnt <= `GXP_CNT_RST;
        end
        gxp_pkg::GXP_CMD_ACK, gxp_pkg::GXP_WDATA_ACK: begin
          st  <= gxp_pkg::GXP_WDATA;
          cnt <= `GXP_CNT_RST;
        end
        gxp_pkg::GXP_RDATA: begin
          if (byte_end) begin
            st <= gxp_pkg::GXP_RDATA_ACK;
          end
        end
        gxp_pkg::GXP_RDATA_ACK: begin
          st  <= nack ? gxp_pkg::GXP_IDLE : gxp_pkg::GXP_RDATA;
          cnt <= `GXP_CNT_RST;
        end
      endcase
    end
  end

  // data line drive: acknowledge bits and read data, changed on falls
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      sda_oe <= 1'b0;
      tx     <= 8'h00;
    end else if (start_ev || stop_ev) begin
      sda_oe <= 1'b0;
    end else if (fall) begin
      unique case (st)
        gxp_pkg::GXP_IDLE, gxp_pkg::GXP_CMD_ACK, gxp_pkg::GXP_WDATA_ACK: begin
          sda_oe <= 1'b0;
        end
        gxp_pkg::GXP_ADDR: begin
          sda_oe <= byte_end & addr_hit;
        end
        gxp_pkg::GXP_CMD, gxp_pkg::GXP_WDATA: begin
          sda_oe <= byte_end;
        end
        gxp_pkg::GXP_ADDR_ACK: begin
          sda_oe <= rw & ~rd_byte[7];
          tx     <= {rd_byte[6:0], 1'b0};
        end
        gxp_pkg::GXP_RDATA: begin
          sda_oe <= ~byte_end & ~tx[7];
          tx     <= {tx[6:0], 1'b0};
        end
        gxp_pkg::GXP_RDATA_ACK: begin
          sda_oe <= ~nack & ~rd_byte[7];
          tx     <= {rd_byte[6:0], 1'b0};
        end
      endcase
    end
  end

  // open-drain data: only low is ever driven
  always_ff @(posedge link_clk) begin
    sda_o <= 1'b0;
  end

  // pointer and requests to the core
  // a request is answered long before the next bit, so one in flight suffices
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      ptr      <= `GXP_PTR_RST;
      req_tgl  <= 1'b0;
      req_we   <= 1'b0;
      req_ptr  <= `GXP_PTR_RST;
      req_data <= 8'h00;
    end else if (fall && byte_end) begin
      if (st == gxp_pkg::GXP_ADDR && addr_hit && shift[0]) begin
        // fetch ahead so the byte is ready when the acknowledge ends
        req_we  <= 1'b0;
        req_ptr <= ptr;
        req_tgl <= ~req_tgl;
      end
      if (st == gxp_pkg::GXP_CMD) begin
        ptr <= shift[2:0];
      end
      if (st == gxp_pkg::GXP_WDATA) begin
        req_we   <= 1'b1;
        req_ptr  <= ptr;
        req_data <= shift;
        req_tgl  <= ~req_tgl;
        ptr      <= ptr ^ 3'h1;  // stays within the pair
      end
      if (st == gxp_pkg::GXP_RDATA) begin
        req_we  <= 1'b0;
        req_ptr <= ptr ^ 3'h1;
        req_tgl <= ~req_tgl;
        ptr     <= ptr ^ 3'h1;
      end
    end
  end

endmodule : gxp_i2c_gpio16

// ### gxp_i2c_gpio16_asserts.sv
`timescale 1ns/1ps
// ==========
// port-level checks of the expander
module gxp_i2c_gpio16_asserts (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        link_clk,
  input  wire logic        reset_n,
  input  wire logic        addr_sel,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic        sda_o,
  input  wire logic        sda_oe,
  input  wire logic        int_n_o,
  input  wire logic        int_n_oe,
  input  wire logic [15:0] port_i,
  input  wire logic [15:0] port_o,
  input  wire logic [15:0] port_oe
);
  logic [7:0]  quiet_cnt; // clk cycles since bus, lines or reset pin moved
  logic        scl_q;     // last sampled bus and line levels
  logic        sda_q;
  logic [15:0] pin_q;

  // ==========
  // quiet counter
  // delayed copies for change detection
  always_ff @(posedge clk) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    pin_q <= port_i;
  end
  // any movement restarts the count
  always_ff @(posedge clk) begin
    if (srst || !reset_n || scl_i != scl_q || sda_i != sda_q || port_i != pin_q) begin
      quiet_cnt <= 8'h00;
    end else if (quiet_cnt != 8'hff) begin
      quiet_cnt <= quiet_cnt + 8'h01;
    end
  end

  // ==========
  // assertions
  rst_defaults_a: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) |-> port_oe == 16'h0000 && port_o == 16'hffff && !int_n_oe && !sda_oe)
    else $error("outputs not at defaults after reset");
  pin_reset_a: assert property (@(posedge clk) disable iff (srst)
    !reset_n [*4] |=> port_oe == 16'h0000 && port_o == 16'hffff && !int_n_oe)
    else $error("reset pin did not reset the outputs");
  all_out_quiet_a: assert property (@(posedge clk) disable iff (srst)
    (port_oe == 16'hffff) [*6] |-> !int_n_oe)
    else $error("interrupt with no input line");
  outputs_hold_a: assert property (@(posedge clk) disable iff (srst)
    quiet_cnt > 8'h64 |-> $stable(port_o) && $stable(port_oe))
    else $error("line drive changed on a quiet bus");
  int_hold_a: assert property (@(posedge clk) disable iff (srst)
    quiet_cnt > 8'h64 |-> $stable(int_n_oe))
    else $error("interrupt moved with bus and lines quiet");
  int_pad_low_a: assert property (@(posedge clk) disable iff (srst)
    int_n_oe |-> int_n_o == 1'b0)
    else $error("interrupt pad not pulled low");
  sda_edge_a: assert property (@(posedge link_clk) disable iff (srst)
    $changed(sda_oe) |-> !scl_i)
    else $error("data pull changed while clock high");
  sda_pad_a: assert property (@(posedge link_clk) disable iff (srst)
    sda_oe |-> sda_o == 1'b0)
    else $error("data pad not pulled low");

  // main scenarios seen
  int_seen_c: cover property (@(posedge clk) disable iff (srst) $rose(int_n_oe));
  pin_rst_c: cover property (@(posedge clk) disable iff (srst) !reset_n [*4]);
  all_out_c: cover property (@(posedge clk) disable iff (srst) (port_oe == 16'hffff) [*6]);
  ack_c: cover property (@(posedge link_clk) disable iff (srst) $rose(sda_oe));
endmodule : gxp_i2c_gpio16_asserts

bind gxp_i2c_gpio16 gxp_i2c_gpio16_asserts chk_u (
  .clk(clk), .srst(srst), .link_clk(link_clk), .reset_n(reset_n), .addr_sel(addr_sel),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .int_n_o(int_n_o),
  .int_n_oe(int_n_oe), .port_i(port_i), .port_o(port_o), .port_oe(port_oe)
);

// ### gxp_i2c_master.sv
`timescale 1ns/1ps
// ==========
// bus master model; scl idles high, sda is only ever pulled low
module gxp_i2c_master (
  input  wire logic link_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_pull
);
  int q = 50; // quarter bit, link cycles
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // one quarter step, moves on falling link edges
  task automatic st(input logic c, input logic p);
    scl = c;
    sda_pull = p;
    repeat (q) @(negedge link_clk);
  endtask : st
  // one bit: data set while scl low, held over the whole high phase
  task automatic bit_io(input logic b, output logic r);
    st(1'b0, ~b);
    st(1'b1, ~b);
    r = sda_line;
    st(1'b1, ~b);
    st(1'b0, ~b);
  endtask : bit_io
  // start or repeated start: sda falls while scl is high
  task automatic start();
    st(scl, 1'b0);
    st(1'b1, 1'b0);
    st(1'b1, 1'b1);
    st(1'b0, 1'b1);
  endtask : start
  // stop: sda rises while scl is high, then the bus stands still
  task automatic stop();
    st(1'b0, 1'b1);
    st(1'b1, 1'b1);
    st(1'b1, 1'b0);
    st(1'b1, 1'b0);
  endtask : stop
  // byte out, msb first; ack is the device pulling sda low in bit 9
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : put_byte
  // byte in; more high acks for another byte, low ends the read
  task automatic get_byte(input logic more, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(~more, r);
  endtask : get_byte
  // pointer then two bytes
  task automatic write(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d0,
                       input logic [7:0] d1, output logic ok);
    logic k;
    start();
    put_byte({a, 1'b0}, ok);
    if (ok) begin
      put_byte(p, k);
      put_byte(d0, k);
      put_byte(d1, k);
    end
    stop();
  endtask : write
  // pointer, repeated start, two bytes read
  task automatic read(input logic [6:0] a, input logic [7:0] p, output logic [7:0] b0,
                      output logic [7:0] b1);
    logic k;
    start();
    put_byte({a, 1'b0}, k);
    put_byte(p, k);
    start();
    put_byte({a, 1'b1}, k);
    get_byte(1'b1, b0);
    get_byte(1'b0, b1);
    stop();
  endtask : read
endmodule : gxp_i2c_master

// ### gxp_i2c_gpio16_tb_top.sv
`timescale 1ns/1ps
`include "gxp_consts.svh"
// ==========
// self-checking bench: bus master, line levels, register model
module gxp_i2c_gpio16_tb_top;
  logic        clk;
  logic        link_clk;
  logic        srst;
  logic        reset_n;
  logic        addr_sel;
  logic        scl;
  logic        sda_pull;  // master pulling the data line
  logic        sda_o;
  logic        sda_oe;
  logic        int_n_o;
  logic        int_n_oe;
  logic [15:0] ext_in;    // outside levels on input lines
  logic [15:0] port_o;
  logic [15:0] port_oe;
  logic [6:0]  dev_a;     // address the master speaks to
  int          cfg[2];    // register model
  int          outv[2];
  int          pol[2];
  int          error_cnt = 0;
  int          n_checks = 0;
  int          cyc = 0;
  // pulled-up wires: low while someone pulls
  wire         sda_line = ~(sda_pull | (sda_oe & ~sda_o));
  wire         int_line = ~(int_n_oe & ~int_n_o);
  // output lines read their own driver
  wire  [15:0] port_i = (port_oe & port_o) | (~port_oe & ext_in);

  gxp_i2c_gpio16 dut_u (
    .clk(clk), .srst(srst), .link_clk(link_clk), .reset_n(reset_n), .addr_sel(addr_sel),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .int_n_o(int_n_o),
    .int_n_oe(int_n_oe), .port_i(port_i), .port_o(port_o), .port_oe(port_oe)
  );
  gxp_i2c_master m_u (.link_clk(link_clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

  // ==========
  // clocks and hang guard
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  // the sequence needs about 60000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ==========
  // model and checks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_pin
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    chk_pin({8'h00, got}, {8'h00, exp});
  endtask : chk_reg
  function automatic logic [7:0] rb();
    return 8'($urandom);
  endfunction : rb
  task automatic model_reset();
    cfg = '{`GXP_CFG_RST, `GXP_CFG_RST};
    outv = '{`GXP_OUT_RST, `GXP_OUT_RST};
    pol = '{`GXP_POL_RST, `GXP_POL_RST};
  endtask : model_reset
  // input register: line level, flipped where the polarity bit is set
  function automatic logic [7:0] exp_reg(input logic [2:0] p);
    case (p[2:1])
      2'h0: return 8'(((~cfg[p[0]] & outv[p[0]]) | (cfg[p[0]] & ext_in[8*p[0] +: 8])) ^ pol[p[0]]);
      2'h1: return 8'(outv[p[0]]);
      2'h2: return 8'(pol[p[0]]);
      default: return 8'(cfg[p[0]]);
    endcase
  endfunction : exp_reg
  // two bytes fill a group pair; the input register takes no writes
  task automatic wr(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1);
    logic ok;
    int   g;
    m_u.write(dev_a, p, d0, d1, ok);
    chk_pin({15'h0000, ok}, 16'h0001);
    for (int i = 0; i < 2; i++) begin
      g = p[0] ^ i;
      case (p[2:1])
        2'h1: outv[g] = i ? d1 : d0;
        2'h2: pol[g] = i ? d1 : d0;
        2'h3: cfg[g] = i ? d1 : d0;
        default: ;
      endcase
    end
  endtask : wr
  task automatic rd_chk(input logic [7:0] p);
    logic [7:0] b0;
    logic [7:0] b1;
    m_u.read(dev_a, p, b0, b1);
    chk_reg(b0, exp_reg(p[2:0]));
    chk_reg(b1, exp_reg(p[2:0] ^ 3'h1));
  endtask : rd_chk
  task automatic chk_ports();
    repeat (4) @(negedge clk);
    chk_pin(port_oe, ~{cfg[1][7:0], cfg[0][7:0]});
    chk_pin(port_o, {outv[1][7:0], outv[0][7:0]});
  endtask : chk_ports
  task automatic int_chk(input logic exp);
    repeat (8) @(negedge clk);
    chk_pin({15'h0000, int_line}, {15'h0000, exp});
  endtask : int_chk

  // ==========
  // main sequence
  initial begin
    logic ok;
    srst = 1'b1;
    reset_n = 1'b1;
    addr_sel = 1'b0;
    ext_in = 16'h0000;
    dev_a = {`GXP_ADDR_HI, 1'b0};
    void'($urandom(32'h735a7d40));
    model_reset();
    repeat (5) @(negedge clk);
    srst = 1'b0;
    repeat (20) @(negedge clk);
    chk_ports();
    for (int p = 0; p < 8; p += 2) rd_chk(8'(p));
    // all outputs, then random directions
    for (int r = 0; r < 2; r++) begin
      @(negedge clk);
      ext_in = 16'($urandom);
      wr(8'h00, rb(), rb());
      wr(8'h02, rb(), rb());
      wr(8'h05, rb(), rb());
      wr(8'h06, r ? rb() : 8'h00, r ? rb() : 8'h00);
      chk_ports();
      for (int p = 0; p < 8; p += 2) rd_chk(8'(p));
    end
    // interrupt: input lines only; read or return releases
    wr(8'h06, 8'h0f, 8'hf0);
    @(negedge clk);
    ext_in = 16'h0000;
    rd_chk(8'h00);
    int_chk(1'b1);
    ext_in[0] = 1'b1;
    int_chk(1'b0);
    ext_in[0] = 1'b0;
    int_chk(1'b1);
    ext_in[13] = 1'b1;
    int_chk(1'b0);
    rd_chk(8'h01);
    int_chk(1'b1);
    // address pin swap, then a slow master
    @(negedge clk);
    addr_sel = 1'b1;
    repeat (20) @(negedge clk);
    m_u.write(dev_a, 8'h02, 8'h00, 8'h00, ok);
    chk_pin({15'h0000, ok}, 16'h0000);
    dev_a = {`GXP_ADDR_HI, 1'b1};
    wr(8'h03, rb(), rb());
    chk_ports();
    m_u.q = 100;
    rd_chk(8'h02);
    m_u.q = 50;
    // reset pin mid-run
    @(negedge clk);
    reset_n = 1'b0;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    model_reset();
    repeat (20) @(negedge clk);
    chk_ports();
    int_chk(1'b1);
    rd_chk(8'h06);
    tally_and_finish();
  end
endmodule : gxp_i2c_gpio16_tb_top
